// >>> verilog/dtisp_pkg.sv
package dtisp_pkg;

    localparam int MEM_AW = 15;
    localparam int REG_AW = 8;
    localparam int ID_MSB = 7;
    localparam int ID_LSB = 4;
    localparam int SEL_MSB = 2;
    localparam int SEL_LSB = 1;
    localparam int RW_BIT = 0;
    localparam int HI_MSB = 6;

    localparam logic [3:0] MEM_ID = 4'ha;
    localparam logic [3:0] REG_ID = 4'hd;
    localparam logic [7:0] REG_LAST = 8'h18;
    localparam logic [14:0] MEM_PTR_LAST = 15'h7fff;
    localparam logic [14:0] MEM_PTR_FIRST = 15'h0000;
    localparam logic [7:0] REG_PTR_FIRST = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] FIRST_BIT = 3'h0;
    localparam logic [2:0] ONE_BIT = 3'h1;
    localparam logic [14:0] MEM_STEP = 15'h0001;
    localparam logic [7:0] REG_STEP = 8'h01;
    localparam logic RELEASED = 1'b1;
    localparam logic PULLED = 1'b0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // pin vector order: supply trip, device select (2), scl, sda
    localparam int PIN_W = 5;
    localparam logic [4:0] PIN_RESET_LVL = 5'h03;
    localparam int PIN_SDA = 0;
    localparam int PIN_SCL = 1;
    localparam int PIN_SEL_LSB = 2;
    localparam int PIN_SEL_MSB = 3;
    localparam int PIN_TRIP = 4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_RX = 3'b010,
        ST_ACK = 3'b011,
        ST_TX = 3'b100,
        ST_MACK = 3'b101
    } dtisp_state_t;

    typedef enum logic [1:0] {
        RX_MEM_HI = 2'b00,
        RX_MEM_LO = 2'b01,
        RX_REG_PTR = 2'b10,
        RX_DATA = 2'b11
    } dtisp_rx_kind_t;

    typedef enum logic {
        TGT_MEM = 1'b0,
        TGT_REG = 1'b1
    } dtisp_target_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [MEM_AW-1:0] addr;
        logic [7:0] data;
    } dtisp_mem_req_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [REG_AW-1:0] addr;
        logic [7:0] data;
    } dtisp_reg_req_t;

    typedef struct packed {
        logic ldMemHi;
        logic ldMemLo;
        logic ldReg;
        logic incMem;
        logic incReg;
        logic [7:0] value;
    } dtisp_ptr_cmd_t;

endpackage

// >>> verilog/dtisp_line_sync.sv
`timescale 1ns/100ps
`default_nettype none

module dtisp_line_sync #(
    parameter int W = 5,
    parameter logic [W-1:0] RESET_LVL = '0
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [W-1:0] raw,
    output logic [W-1:0] lvl,
    output logic [W-1:0] rose,
    output logic [W-1:0] fell
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] lvl;
    } dtisp_sync_state_t;

    dtisp_sync_state_t state_reg;
    dtisp_sync_state_t state_next;
    logic [W-1:0] agree;

    // a change counts only once the second and third stage agree
    assign agree = ~(state_reg.ff2 ^ state_reg.ff3);
    assign rose = agree & state_reg.ff3 & ~state_reg.lvl; // see R25
    assign fell = agree & ~state_reg.ff3 & state_reg.lvl; // see R25
    assign lvl = state_reg.lvl;

    always_comb begin
        state_next = state_reg;
        state_next.ff1 = raw;
        state_next.ff2 = state_reg.ff1;
        state_next.ff3 = state_reg.ff2;
        state_next.lvl = (agree & state_reg.ff3) | (~agree & state_reg.lvl); // see R25
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= {RESET_LVL, RESET_LVL, RESET_LVL, RESET_LVL};
        end else begin
            state_reg <= state_next;
        end
    end

    a_sync_filter_agree: assert property (@(posedge mclk) disable iff (reset) // see R25
        ((state_reg.lvl ^ $past(state_reg.lvl)) & $past(state_reg.ff2 ^ state_reg.ff3)) == '0)
        else $error("filtered level moved while late stages disagreed");

endmodule

`default_nettype wire

// >>> verilog/dtisp_pointers.sv
`timescale 1ns/100ps
`default_nettype none

module dtisp_pointers
    import dtisp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire dtisp_ptr_cmd_t cmd,
    output logic [MEM_AW-1:0] memPtr,
    output logic [REG_AW-1:0] regPtr
);
    typedef struct packed {
        logic [HI_MSB:0] memHi;
        logic [MEM_AW-1:0] memPtr;
        logic [REG_AW-1:0] regPtr;
    } dtisp_ptr_state_t;

    dtisp_ptr_state_t state_reg;
    dtisp_ptr_state_t state_next;

    assign memPtr = state_reg.memPtr;
    assign regPtr = state_reg.regPtr;

    // separate pointers: one target never moves the other
    always_comb begin
        state_next = state_reg; // see R14, R23
        if (cmd.ldMemHi) begin
            state_next.memHi = cmd.value[HI_MSB:0];
        end
        if (cmd.ldMemLo) begin
            state_next.memPtr = {state_reg.memHi, cmd.value}; // see R13
        end else if (cmd.incMem) begin
            // natural 15-bit rollover from the top location to zero
            state_next.memPtr = state_reg.memPtr + MEM_STEP; // see R15, R16
        end
        if (cmd.ldReg) begin
            state_next.regPtr = cmd.value;
        end else if (cmd.incReg) begin
            state_next.regPtr = state_reg.regPtr + REG_STEP; // see R15
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    a_mem_ptr_wrap: assert property (@(posedge mclk) disable iff (reset) // see R16
        cmd.incMem && !cmd.ldMemLo && state_reg.memPtr == MEM_PTR_LAST
        |=> state_reg.memPtr == MEM_PTR_FIRST)
        else $error("memory pointer did not wrap to zero");

    a_mem_ptr_load: assert property (@(posedge mclk) disable iff (reset) // see R13
        cmd.ldMemLo && !cmd.ldMemHi
        |=> state_reg.memPtr == {$past(state_reg.memHi), $past(cmd.value)})
        else $error("memory pointer not loaded from two address bytes");

    a_pointers_apart: assert property (@(posedge mclk) disable iff (reset) // see R23
        (cmd.ldReg || cmd.incReg) && !cmd.ldMemLo && !cmd.incMem
        |=> $stable(state_reg.memPtr))
        else $error("register access moved the memory pointer");

endmodule

`default_nettype wire

// >>> verilog/dtisp_slave_port.sv
// What this block does
// R1 - detect start and stop conditions on the bus
// R2 - stop abandons any operation at once
// R3 - start aborts and awaits a new address
// R4 - sample on clock high, change on low
// R5 - ninth slot: transmitter releases, receiver pulls low
// R6 - no acknowledge ends the operation, readdressable
// R7 - keep sending bytes while master acknowledges
// R8 - master withholds acknowledge on last byte
// R9 - upper address nibble picks memory or registers
// R10 - register transactions never touch the memory
// R11 - address bits two and one match pins
// R12 - address bit zero: one reads, zero writes
// R13 - two address bytes load fifteen bit pointer
// R14 - reads start at a retained pointer value
// R15 - pointer increments after each byte, before acknowledge
// R16 - memory pointer wraps from top to zero
// R17 - no limit on bytes per transaction
// R18 - register pointer is one byte, 00h-18h (here auto-increment carries it past 18h, up to FFh)
// R19 - register address above 18h is refused
// R20 - writes: take eight bits, then acknowledge
// R21 - all bytes travel most significant bit first
// R22 - supply below trip voltage aborts any transaction
// R23 - memory and register pointers stay independent
// R24 - repeated start after address makes selective read
// R25 - filter both lines; drive data low only
`timescale 1ns/100ps
`default_nettype none

module dtisp_slave_port
    import dtisp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    input wire logic [1:0] devSelPins,
    input wire logic belowSupplyTripVoltage,
    output dtisp_mem_req_t memReq,
    input wire logic [7:0] memRdData,
    output dtisp_reg_req_t regReq,
    input wire logic [7:0] regRdData
);
    typedef struct packed {
        dtisp_state_t st;
        dtisp_rx_kind_t kind;
        dtisp_target_t tgt;
        logic readDir;
        logic [2:0] bitCnt;
        logic gotByte;
        logic mackOk;
        logic [7:0] shift;
        logic fetchReq;
        logic fetchCap;
        logic sdaOut;
        logic sdaOeN;
        dtisp_mem_req_t memReq;
        dtisp_reg_req_t regReq;
    } dtisp_port_state_t;

    dtisp_port_state_t state_reg;
    dtisp_port_state_t state_next;
    dtisp_ptr_cmd_t ptrCmd;
    logic [MEM_AW-1:0] memPtr;
    logic [REG_AW-1:0] regPtr;
    logic [PIN_W-1:0] pinLvl;
    logic [PIN_W-1:0] pinRose;
    logic [PIN_W-1:0] pinFell;
    logic sclLvl;
    logic sdaLvl;
    logic sclRise;
    logic sclFall;
    logic startDet;
    logic stopDet;
    logic tripLvl;
    logic [1:0] selLvl;
    logic [7:0] byteIn;
    logic idMem;
    logic idReg;
    logic addrHit;

    dtisp_line_sync #(
        .W(PIN_W),
        .RESET_LVL(PIN_RESET_LVL)
    ) u_sync (
        .mclk(mclk),
        .reset(reset),
        .raw({belowSupplyTripVoltage, devSelPins, scl, sdaIn}),
        .lvl(pinLvl),
        .rose(pinRose),
        .fell(pinFell)
    );

    dtisp_pointers u_ptrs (
        .mclk(mclk),
        .reset(reset),
        .cmd(ptrCmd),
        .memPtr(memPtr),
        .regPtr(regPtr)
    );

    assign sclLvl = pinLvl[PIN_SCL];
    assign sdaLvl = pinLvl[PIN_SDA];
    assign sclRise = pinRose[PIN_SCL];
    assign sclFall = pinFell[PIN_SCL];
    assign tripLvl = pinLvl[PIN_TRIP];
    assign selLvl = pinLvl[PIN_SEL_MSB:PIN_SEL_LSB];
    assign startDet = pinFell[PIN_SDA] && sclLvl; // see R1
    assign stopDet = pinRose[PIN_SDA] && sclLvl; // see R1

    // shift in msb first
    assign byteIn = {state_reg.shift[6:0], sdaLvl}; // see R21
    assign idMem = state_reg.shift[ID_MSB:ID_LSB] == MEM_ID; // see R9
    assign idReg = state_reg.shift[ID_MSB:ID_LSB] == REG_ID; // see R9
    assign addrHit = (idMem || idReg)
        && state_reg.shift[SEL_MSB:SEL_LSB] == selLvl; // see R11

    assign sdaOut = state_reg.sdaOut;
    assign sdaOeN = state_reg.sdaOeN;
    assign memReq = state_reg.memReq;
    assign regReq = state_reg.regReq;

    always_comb begin
        state_next = state_reg;
        ptrCmd = '0;
        ptrCmd.value = state_reg.shift;
        state_next.sdaOut = PULLED; // see R25
        state_next.memReq.wr = 1'b0;
        state_next.memReq.rd = 1'b0;
        state_next.regReq.wr = 1'b0;
        state_next.regReq.rd = 1'b0;
        state_next.fetchReq = 1'b0;
        state_next.fetchCap = state_reg.memReq.rd || state_reg.regReq.rd;

        // read fetch: strobe one cycle, capture the cycle after
        if (state_reg.fetchReq) begin
            if (state_reg.tgt == TGT_MEM) begin
                state_next.memReq.rd = 1'b1;
                state_next.memReq.addr = memPtr; // see R14
            end else begin
                state_next.regReq.rd = 1'b1;
                state_next.regReq.addr = regPtr; // see R14
            end
        end
        if (state_reg.fetchCap) begin
            state_next.shift = (state_reg.tgt == TGT_MEM) ? memRdData : regRdData;
        end

        unique case (state_reg.st)
            ST_IDLE: begin
                state_next.sdaOeN = RELEASED;
            end
            ST_ADDR, ST_RX: begin
                if (sclRise) begin
                    state_next.shift = byteIn; // see R4, R21
                    state_next.bitCnt = state_reg.bitCnt + ONE_BIT;
                    state_next.gotByte = state_reg.bitCnt == LAST_BIT; // see R20
                end else if (sclFall && state_reg.gotByte) begin
                    state_next.gotByte = 1'b0;
                    state_next.bitCnt = FIRST_BIT;
                    state_next.st = ST_ACK;
                    state_next.sdaOeN = PULLED; // see R5, R20
                    if (state_reg.st == ST_ADDR) begin
                        if (addrHit) begin
                            state_next.tgt = idMem ? TGT_MEM : TGT_REG; // see R9, R10
                            state_next.readDir = state_reg.shift[RW_BIT]; // see R12
                            state_next.kind = idMem ? RX_MEM_HI : RX_REG_PTR;
                            // read starts from the retained pointer
                            state_next.fetchReq = state_reg.shift[RW_BIT]; // see R14, R24
                        end else begin
                            state_next.st = ST_IDLE;
                            state_next.sdaOeN = RELEASED;
                        end
                    end else begin
                        unique case (state_reg.kind)
                            RX_MEM_HI: begin
                                ptrCmd.ldMemHi = 1'b1; // see R13
                                state_next.kind = RX_MEM_LO;
                            end
                            RX_MEM_LO: begin
                                ptrCmd.ldMemLo = 1'b1; // see R13
                                state_next.kind = RX_DATA;
                            end
                            RX_REG_PTR: begin
                                if (state_reg.shift > REG_LAST) begin
                                    state_next.st = ST_IDLE; // see R19
                                    state_next.sdaOeN = RELEASED; // see R19
                                end else begin
                                    ptrCmd.ldReg = 1'b1; // see R18
                                    state_next.kind = RX_DATA;
                                end
                            end
                            RX_DATA: begin
                                // write lands after the eighth bit, then advance
                                if (state_reg.tgt == TGT_MEM) begin
                                    state_next.memReq.wr = 1'b1;
                                    state_next.memReq.addr = memPtr;
                                    state_next.memReq.data = state_reg.shift;
                                    ptrCmd.incMem = 1'b1; // see R15, R17
                                end else begin
                                    state_next.regReq.wr = 1'b1; // see R10
                                    state_next.regReq.addr = regPtr;
                                    state_next.regReq.data = state_reg.shift;
                                    ptrCmd.incReg = 1'b1; // see R15, R17
                                end
                            end
                        endcase
                    end
                end
            end
            ST_ACK: begin
                if (sclFall) begin
                    state_next.bitCnt = FIRST_BIT;
                    if (state_reg.readDir) begin
                        state_next.st = ST_TX;
                        state_next.sdaOeN = state_reg.shift[7]; // see R21, R25
                    end else begin
                        state_next.st = ST_RX; // see R4
                        state_next.sdaOeN = RELEASED; // see R5
                    end
                end
            end
            ST_TX: begin
                if (sclFall) begin
                    if (state_reg.bitCnt == LAST_BIT) begin
                        state_next.st = ST_MACK;
                        state_next.sdaOeN = RELEASED; // see R5
                        state_next.fetchReq = 1'b1;
                        ptrCmd.incMem = state_reg.tgt == TGT_MEM; // see R15, R10
                        ptrCmd.incReg = state_reg.tgt == TGT_REG; // see R15
                    end else begin
                        state_next.shift = {state_reg.shift[6:0], 1'b0};
                        state_next.sdaOeN = state_reg.shift[6]; // see R4, R21
                        state_next.bitCnt = state_reg.bitCnt + ONE_BIT;
                    end
                end
            end
            ST_MACK: begin
                if (sclRise) begin
                    state_next.mackOk = !sdaLvl;
                    if (sdaLvl) begin
                        state_next.st = ST_IDLE; // see R6, R8
                    end
                end else if (sclFall && state_reg.mackOk) begin
                    state_next.st = ST_TX; // see R7, R17
                    state_next.bitCnt = FIRST_BIT;
                    state_next.sdaOeN = state_reg.shift[7]; // see R21
                end
            end
            default: begin
                state_next.st = ST_IDLE;
                state_next.sdaOeN = RELEASED;
            end
        endcase

        // aborts: supply trip over start over stop
        if (tripLvl) begin
            state_next.st = ST_IDLE; // see R22
            state_next.sdaOeN = RELEASED;
        end else if (startDet) begin
            state_next.st = ST_ADDR; // see R3, R24
            state_next.bitCnt = FIRST_BIT;
            state_next.gotByte = 1'b0;
            state_next.sdaOeN = RELEASED;
        end else if (stopDet) begin
            state_next.st = ST_IDLE; // see R2
            state_next.sdaOeN = RELEASED;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.st <= ST_IDLE;
            state_reg.sdaOeN <= RELEASED;
            state_reg.sdaOut <= PULLED;
        end else begin
            state_reg <= state_next;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_stop_abandons: assert property (stopDet && !tripLvl && !startDet // see R2
        |=> state_reg.st == ST_IDLE && state_reg.sdaOeN)
        else $error("stop did not abandon the operation");

    a_start_rearms: assert property (startDet && !tripLvl // see R3
        |=> state_reg.st == ST_ADDR && state_reg.bitCnt == FIRST_BIT && state_reg.sdaOeN)
        else $error("start did not return to address reception");

    a_drive_on_low: assert property ($changed(state_reg.sdaOeN) // see R4
        && !$past(startDet || stopDet || tripLvl) && $past(state_reg.st) != ST_IDLE
        |-> $past(sclFall) || !$past(sclLvl))
        else $error("data line changed while clock was high");

    a_never_drive_high: assert property (state_reg.sdaOut == PULLED) // see R25
        else $error("data line output not held low");

    a_ack_slot_levels: assert property (state_reg.st == ST_ACK |-> !state_reg.sdaOeN) // see R5
        else $error("acknowledge slot drive wrong");

    a_master_release: assert property (state_reg.st == ST_MACK |-> state_reg.sdaOeN) // see R5
        else $error("device drove line in master acknowledge slot");

    a_nack_ends_read: assert property (state_reg.st == ST_MACK && sclRise && sdaLvl // see R6
        && !startDet && !stopDet && !tripLvl |=> state_reg.st == ST_IDLE)
        else $error("no-acknowledge did not end the read");

    a_ack_continues: assert property (state_reg.st == ST_MACK && state_reg.mackOk // see R7
        && sclFall && !startDet && !stopDet && !tripLvl
        |=> state_reg.st == ST_TX && state_reg.bitCnt == FIRST_BIT)
        else $error("acknowledged read did not continue");

    a_select_pins: assert property (state_reg.st == ST_ACK && $past(state_reg.st) == ST_ADDR // see R11
        |-> $past(state_reg.shift[SEL_MSB:SEL_LSB]) == $past(selLvl))
        else $error("acknowledged an address with wrong select bits");

    a_reg_leaves_mem: assert property (state_reg.tgt == TGT_REG // see R10
        |-> !ptrCmd.incMem && !ptrCmd.ldMemLo && !ptrCmd.ldMemHi && !state_reg.memReq.wr)
        else $error("register transaction touched memory");

    a_reg_range: assert property (state_reg.st == ST_RX && state_reg.kind == RX_REG_PTR // see R19
        && sclFall && state_reg.gotByte && state_reg.shift > REG_LAST && !startDet && !tripLvl
        |=> state_reg.st == ST_IDLE ##1 state_reg.sdaOeN)
        else $error("illegal register address was accepted");

    a_trip_aborts: assert property (tripLvl |=> state_reg.st == ST_IDLE [*2]) // see R22
        else $error("supply trip did not abort");

endmodule

`default_nettype wire

// >>> tb/dtisp_master_model.sv
`timescale 1ns/100ps
`default_nettype none

module dtisp_master_model (
    output logic scl,
    output logic sdaOeN,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sdaOeN = 1'b1;
    end
    task automatic start();
        #10 sdaOeN = 1'b1;
        #40 scl = 1'b1;
        #50 sdaOeN = 1'b0;
        #50 scl = 1'b0;
    endtask
    task automatic stop();
        #10 sdaOeN = 1'b0;
        #40 scl = 1'b1;
        #50 sdaOeN = 1'b1;
        #50;
    endtask
    // data moves only while clock low, sampled late in the high phase
    task automatic bit_io(input logic b, output logic r);
        #10 sdaOeN = b;
        #40 scl = 1'b1;
        #30 r = sda;
        scl = 1'b0;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd_byte(input logic mAck, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~mAck, r);
    endtask
endmodule

`default_nettype wire

// >>> tb/dtisp_slave_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module dtisp_slave_port_tb_top;
    import dtisp_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic scl, mOeN, sdaOut, sdaOeN;
    logic trip = 1'b0;
    logic [1:0] sel = 2'h2;
    dtisp_mem_req_t memReq;
    dtisp_reg_req_t regReq;
    logic [7:0] memRdData = 8'h00;
    logic [7:0] regRdData = 8'h00;
    logic [7:0] mem [0:32767];
    logic [7:0] regs [0:255];
    int errTotal = 0;
    int samplesChecked = 0;
    int memWrites = 0;
    wire logic sda = mOeN & (sdaOeN | sdaOut);

    dtisp_slave_port dtisp_slave_port_inst (.mclk(mclk), .reset(reset), .scl(scl),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .devSelPins(sel),
        .belowSupplyTripVoltage(trip), .memReq(memReq), .memRdData(memRdData),
        .regReq(regReq), .regRdData(regRdData));
    dtisp_master_model dtisp_master_model_inst (.scl(scl), .sdaOeN(mOeN), .sda(sda));

    initial forever #5 mclk = ~mclk;

    // read data is only good the cycle after a fetch
    always @(posedge mclk) begin
        if (memReq.wr) begin
            mem[memReq.addr] <= memReq.data;
            memWrites <= memWrites + 1;
        end
        if (regReq.wr) regs[regReq.addr] <= regReq.data;
        memRdData <= memReq.rd ? mem[memReq.addr] : ~memRdData;
        regRdData <= regReq.rd ? regs[regReq.addr] : ~regRdData;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errTotal++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic busStart();
        dtisp_master_model_inst.start();
    endtask
    task automatic busStop();
        dtisp_master_model_inst.stop();
    endtask
    task automatic send(input logic [7:0] b, input logic expAck);
        logic a;
        dtisp_master_model_inst.wr_byte(b, a);
        check(16'(a), 16'(expAck));
    endtask
    task automatic recv(input logic mAck, input logic [7:0] exp);
        logic [7:0] d;
        dtisp_master_model_inst.rd_byte(mAck, d);
        check(16'(d), 16'(exp));
    endtask
    task automatic setPins(input logic [1:0] s, input logic t);
        @(posedge mclk);
        #1 sel = s;
        trip = t;
    endtask
    task automatic setPtr(input logic [7:0] id, input logic [15:0] p);
        busStart();
        send(id, 1'b1);
        send(p[15:8], 1'b1);
        send(p[7:0], 1'b1);
    endtask

    task automatic testMemory();
        setPtr(8'ha4, 16'h0123);
        for (int i = 0; i < 3; i++) send(8'h5a ^ 8'(i), 1'b1);
        busStop();
        for (int i = 0; i < 3; i++) check(16'(mem[15'h0123 + 15'(i)]), 16'(8'h5a ^ 8'(i)));
        setPtr(8'ha4, 16'h0123);
        busStart();
        send(8'ha5, 1'b1);
        recv(1'b1, 8'h5a);
        recv(1'b0, 8'h5b);
        busStop();
        $display("memory test done");
    endtask
    task automatic testRegisters();
        int w0;
        w0 = memWrites;
        busStart();
        send(8'hd4, 1'b1);
        send(8'h19, 1'b0);
        busStop();
        busStart();
        send(8'hd4, 1'b1);
        send(8'h18, 1'b1);
        send(8'h77, 1'b1);
        busStop();
        busStart();
        send(8'hd4, 1'b1);
        send(8'h18, 1'b1);
        busStart();
        send(8'hd5, 1'b1);
        recv(1'b0, 8'h77);
        busStop();
        check(16'(memWrites), 16'(w0));
        busStart();
        send(8'ha5, 1'b1);
        recv(1'b0, 8'h58);
        busStop();
        $display("register test done");
    endtask
    task automatic testWrap();
        setPtr(8'ha4, 16'h7fff);
        send(8'h11, 1'b1);
        send(8'h22, 1'b1);
        busStop();
        check(16'(mem[15'h7fff]), 16'h0011);
        check(16'(mem[15'h0000]), 16'h0022);
        $display("wrap test done");
    endtask
    task automatic testSelect();
        for (int s = 0; s < 4; s++) begin
            setPins(2'(s), 1'b0);
            busStart();
            send({4'ha, 1'b0, ~2'(s), 1'b0}, 1'b0);
            busStart();
            send({4'hd, 1'b0, 2'(s), 1'b0}, 1'b1);
            busStop();
        end
        busStart();
        send(8'hb4, 1'b0);
        busStop();
        $display("select test done");
    endtask
    task automatic testAborts();
        logic r;
        int w0;
        w0 = memWrites;
        setPins(2'h2, 1'b0);
        setPtr(8'ha4, 16'h0200);
        for (int i = 0; i < 5; i++) dtisp_master_model_inst.bit_io(1'b0, r);
        busStop();
        setPtr(8'ha4, 16'h0200);
        for (int i = 0; i < 7; i++) dtisp_master_model_inst.bit_io(1'b1, r);
        busStart();
        send(8'ha4, 1'b1);
        setPins(2'h2, 1'b1);
        send(8'h02, 1'b0);
        setPins(2'h2, 1'b0);
        busStop();
        check(16'(memWrites), 16'(w0));
        $display("abort test done");
    endtask

    initial begin
        repeat (30000) @(posedge mclk);
        errTotal++;
        tallyAndFinish();
    end
    initial begin
        repeat (10) @(posedge mclk);
        #1 reset = 1'b0;
        repeat (4) @(posedge mclk);
        // keep every pin change off the sampling edge
        #1;
        testMemory();
        testRegisters();
        testWrap();
        testSelect();
        testAborts();
        tallyAndFinish();
    end
endmodule

`default_nettype wire
